// ---- core/bitbang_pkg.sv ----
// Purpose: Shared constants for the parallel bit-bang port
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Mode codes follow the host mode-select command
package bitbang_pkg;
  localparam int          PORT_W         = 8;
  localparam logic [7:0]  MODE_OFF       = 8'h00;
  localparam logic [7:0]  MODE_FREE      = 8'h01;
  localparam logic [7:0]  MODE_SYNC      = 8'h04;
  localparam logic [7:0]  DIR_RESET      = 8'h00;
  localparam logic [7:0]  PINS_RESET     = 8'h00;
  localparam logic [2:0]  STROBE_CYCLES  = 3'h1;
  localparam int          SETUP_NS       = 10;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam logic [2:0]  SETUP_CYCLES   =
    3'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_DRIVE  = 3'b011,
    ST_SETUP  = 3'b010,
    ST_WSTB   = 3'b110
  } sync_state_t;
endpackage

// ---- core/bitbang_port.sv ----
// Purpose: Parallel bit-bang port between USB FIFOs and eight I/O pins
// Assumes: Pins are asynchronous and pass a two-stage synchroniser
// Notes:   Mode and direction come from the host setup command
//
// How it works
// - Free-running mode brings internal read and write strobes out on pins.
// - Each port bit is individually an input or an output.
// - Free-running output is paced by the baud-rate generator tick.
// - Free-running pins change only with a new byte and a tick.
// - Without a new byte, output pins hold the last written value.
// - Mode code 0x01 selects free-running bit-bang mode.
// - Synchronous mode updates outputs only when a byte arrives from USB.
// - Synchronous write strobe pulses after the byte is taken and driven.
// - Synchronous samples are taken only because of a written byte.
// - Synchronous bytes are processed only while the transmit FIFO has room.
// - Pins are sampled before driving, so samples trail output one byte.
// - Mode code 0x04 selects synchronous bit-bang mode.
// - Sequence: read, release read strobe and send, drive, setup, write strobe.
// - In synchronous mode the read strobe rising edge marks the captured sample.
// - Pin directions come from the byte mask of the setup command.
// - Directions hold until another setup command arrives.
`timescale 1ns/10ps
`default_nettype none
module bitbang_port
  import bitbang_pkg::*;
#(
  parameter int WIDTH = bitbang_pkg::PORT_W
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             setup_valid,
  input  wire logic [7:0]       setup_mode,
  input  wire logic [WIDTH-1:0] setup_dir_mask,
  input  wire logic             baud_tick,
  input  wire logic             rx_valid,
  input  wire logic [WIDTH-1:0] rx_data,
  output logic                  rx_ready,
  output logic                  tx_valid,
  output logic [WIDTH-1:0]      tx_data,
  input  wire logic             tx_ready,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0]      pin_out,
  output logic [WIDTH-1:0]      pin_oe,
  output logic                  pin_sample_strobe_n,
  output logic                  pin_update_strobe_n
);
  import bitbang_pkg::*;

  logic [7:0]       mode_reg;
  logic [WIDTH-1:0] dir_reg;
  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] hold_reg;
  logic             rx_ready_reg;
  logic             tx_valid_reg;
  logic [WIDTH-1:0] tx_data_reg;
  logic             rstb_n_reg;
  logic             wstb_n_reg;
  logic [2:0]       cnt_reg;
  logic [2:0]       cnt_next;
  sync_state_t      state_reg;
  sync_state_t      state_next;

  wire free_mode  = (mode_reg == MODE_FREE);
  wire sync_mode  = (mode_reg == MODE_SYNC);
  wire free_take  = free_mode && rx_valid && baud_tick;
  wire sync_start = sync_mode && (state_reg == ST_IDLE) && rx_valid && tx_ready
                    && !tx_valid_reg;
  wire cnt_done   = (cnt_reg == 3'h0);

  // Shared down-count for the setup and strobe timers
  function automatic logic [2:0] cnt_dec(input logic [2:0] value);
    return value - 3'h1;
  endfunction

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_reg <= MODE_OFF;
      dir_reg  <= DIR_RESET;
    end else if (setup_valid) begin
      mode_reg <= setup_mode;
      dir_reg  <= setup_dir_mask;
    end
  end

  // Two stages before any logic looks at the pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= PINS_RESET;
      sync2_reg <= PINS_RESET;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (sync_start) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: state_next = ST_DRIVE;
      ST_DRIVE: begin
        state_next = ST_SETUP;
        cnt_next   = cnt_dec(SETUP_CYCLES);
      end
      ST_SETUP: begin
        if (cnt_done) begin
          state_next = ST_WSTB;
          cnt_next   = cnt_dec(STROBE_CYCLES);
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      ST_WSTB: begin
        if (cnt_done) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!sync_mode) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Byte held from take until drive; keeps sample ahead of the update
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_reg     <= PINS_RESET;
      rx_ready_reg <= 1'b0;
    end else begin
      rx_ready_reg <= 1'b0;
      if (sync_start || (free_take && !rx_ready_reg)) begin
        hold_reg     <= rx_data;
        rx_ready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      out_reg <= PINS_RESET;
    end else if (free_mode && rx_ready_reg) begin
      out_reg <= hold_reg;
    end else if (sync_mode && (state_reg == ST_DRIVE)) begin
      // update on USB byte
      // Mode guard keeps an aborted sync cycle off the pins
      out_reg <= hold_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= PINS_RESET;
    end else if (state_reg == ST_SAMPLE) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg  <= sync2_reg;
    end else if (free_mode && baud_tick && !tx_valid_reg) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg  <= sync2_reg;
    end else if (tx_ready) begin
      tx_valid_reg <= 1'b0;
    end
  end

  // Sync idle holds the read strobe low, so its rise marks a capture
  // strobes on pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      rstb_n_reg <= 1'b0;
      wstb_n_reg <= 1'b1;
    end else if (free_mode) begin
      rstb_n_reg <= !(baud_tick && !tx_valid_reg);
      wstb_n_reg <= !rx_ready_reg;
    end else begin
      rstb_n_reg <= (state_next == ST_DRIVE) ? 1'b1 : 1'b0;
      wstb_n_reg <= (state_next != ST_WSTB);
    end
  end

  assign pin_oe              = dir_reg;
  assign pin_out             = out_reg;
  assign rx_ready            = rx_ready_reg;
  assign tx_valid            = tx_valid_reg;
  assign tx_data             = tx_data_reg;
  assign pin_sample_strobe_n = rstb_n_reg;
  assign pin_update_strobe_n = wstb_n_reg;

  a_dir_hold: assert property (@(posedge mclk) disable iff (reset)
    !setup_valid |=> $stable(pin_oe))
    else $error("direction changed without setup");
  a_free_change: assert property (@(posedge mclk) disable iff (reset)
    (free_mode && $changed(pin_out)) |-> $past(free_take, 2))
    else $error("free output changed without byte and tick");
  a_sync_change: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && $changed(pin_out)) |-> $past(state_reg) == ST_DRIVE)
    else $error("sync output changed outside drive step");
  a_sync_order: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && state_reg == ST_SAMPLE) |=> state_reg == ST_DRIVE ##1
    state_reg == ST_SETUP ##1 state_reg == ST_WSTB)
    else $error("synchronous step order broken");
  a_wstb_pulse: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && $fell(pin_update_strobe_n)) |-> $past(state_reg, 1) == ST_SETUP
    ##1 pin_update_strobe_n)
    else $error("write strobe not a one-cycle pulse after setup");
  a_rstb_rise: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && $rose(pin_sample_strobe_n)) |-> tx_valid)
    else $error("read strobe rose without a sample");
  a_sample_cause: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && $rose(tx_valid)) |-> $past(state_reg) == ST_SAMPLE)
    else $error("sample without a written byte");
  a_room_needed: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && rx_ready) |-> $past(tx_ready) && !$past(tx_valid))
    else $error("byte started without transmit room");
  a_free_mode: assert property (@(posedge mclk) disable iff (reset)
    (setup_valid && setup_mode == MODE_FREE) |=> free_mode)
    else $error("free mode code not taken");
  a_sync_mode: assert property (@(posedge mclk) disable iff (reset)
    (setup_valid && setup_mode == MODE_SYNC) |=> sync_mode)
    else $error("sync mode code not taken");
  a_oe_mask: assert property (@(posedge mclk) disable iff (reset)
    setup_valid |=> pin_oe == $past(setup_dir_mask))
    else $error("direction mask not applied");

  // Free-running pacing, hold and strobes
  a_tick_take: assert property (@(posedge mclk) disable iff (reset)
    (free_take && !rx_ready) |=> rx_ready)
    else $error("byte and tick did not take a byte");
  a_free_hold: assert property (@(posedge mclk) disable iff (reset)
    (free_mode && !rx_ready) |=> $stable(pin_out))
    else $error("free output moved without a new byte");
  a_free_wstb: assert property (@(posedge mclk) disable iff (reset)
    (free_mode && rx_ready) |=> !pin_update_strobe_n)
    else $error("free write strobe missing");
  a_free_wstb_one: assert property (@(posedge mclk) disable iff (reset)
    (free_mode && !pin_update_strobe_n) |=> pin_update_strobe_n)
    else $error("free write strobe longer than one cycle");
  a_free_rstb: assert property (@(posedge mclk) disable iff (reset)
    (free_mode && baud_tick && !tx_valid) |=> !pin_sample_strobe_n)
    else $error("free read strobe missing on tick");
  a_tick_sample: assert property (@(posedge mclk) disable iff (reset)
    (free_mode && baud_tick && !tx_valid) |=> tx_valid)
    else $error("tick did not sample the pins");

  // Synchronous handshake and strobe timing
  a_take_pulse: assert property (@(posedge mclk) disable iff (reset)
    rx_ready |=> !rx_ready)
    else $error("receive ready longer than one cycle");
  a_sync_pair: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && rx_ready) |=> tx_valid)
    else $error("taken byte gave no sample");
  a_update_rstb: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && $changed(pin_out)) |-> !pin_sample_strobe_n)
    else $error("read strobe not back low at output update");
  a_setup_gap: assert property (@(posedge mclk) disable iff (reset)
    (sync_mode && $changed(pin_out)) |-> pin_update_strobe_n ##1 !pin_update_strobe_n)
    else $error("write strobe missing one clock setup");

  c_sync_byte: cover property (@(posedge mclk) disable iff (reset)
    sync_mode && $fell(pin_update_strobe_n));
  c_free_byte: cover property (@(posedge mclk) disable iff (reset)
    free_mode && $changed(pin_out));
  c_sync_stall: cover property (@(posedge mclk) disable iff (reset)
    sync_mode && rx_valid && !tx_ready);
  c_free_sample: cover property (@(posedge mclk) disable iff (reset)
    free_mode && $fell(pin_sample_strobe_n));
  c_all_inputs: cover property (@(posedge mclk) disable iff (reset)
    sync_mode && (pin_oe == '0) && $fell(pin_update_strobe_n));
endmodule // bitbang_port
`default_nettype wire

// ---- tb/pin_partner.sv ----
// Purpose: Outside logic on the parallel pins
// Assumes: Port drivers win on output pins
// Notes:   Inputs carry the outside value
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pin_in
);
  assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule // pin_partner
`default_nettype wire

// ---- tb/test_usb_parallel_bit_bang_port.sv ----
// Purpose: Self-checking bench for the bit-bang port
// Assumes: Timing as in the hand-over walk
// Notes:   Pins resolved by the partner model
`timescale 1ns/10ps
`default_nettype none
module test_usb_parallel_bit_bang_port;
  import bitbang_pkg::*;
  logic       mclk, reset, setup_valid, baud_tick, rx_valid, tx_ready;
  logic [7:0] setup_mode, setup_dir_mask, rx_data, ext_val, tx_data;
  logic [7:0] pin_in, pin_out, pin_oe, held;
  logic       rx_ready, tx_valid, pin_sample_strobe_n, pin_update_strobe_n;
  int         failures, checked;

  bitbang_port uut (.mclk, .reset, .setup_valid, .setup_mode, .setup_dir_mask,
    .baud_tick, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
    .pin_in, .pin_out, .pin_oe, .pin_sample_strobe_n, .pin_update_strobe_n);
  pin_partner ext (.pin_out, .pin_oe, .ext_val, .pin_in);

  task automatic check(input logic [7:0] seen, exp, input string msg);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic setup(input logic [7:0] m, d);
    @(posedge mclk);
    setup_valid <= 1;
    setup_mode <= m;
    setup_dir_mask <= d;
    @(posedge mclk);
    setup_valid <= 0;
    #1;
    check(pin_oe, d, "direction");
  endtask

  // Bounded wait so a dead handshake cannot hang
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (rx_ready !== 1'b1 && n < 20);
    @(posedge mclk);
    rx_valid <= 0;
    #1;
  endtask

  task automatic send(input logic [7:0] b, exp_s, exp_p);
    @(posedge mclk);
    rx_valid <= 1;
    rx_data <= b;
    wait_ack();
    check(tx_valid, 1, "sample valid");
    check(tx_data, exp_s, "sample");
    check(pin_sample_strobe_n, 1, "rstb up");
    @(posedge mclk);
    #1;
    check(pin_in, exp_p, "pins");
    check(pin_sample_strobe_n, 0, "rstb down");
    check(pin_update_strobe_n, 1, "wstb setup");
    @(posedge mclk);
    #1;
    check(pin_update_strobe_n, 0, "wstb");
    @(posedge mclk);
    #1;
    check(pin_update_strobe_n, 1, "wstb end");
  endtask

  task automatic t_sync();
    setup(MODE_SYNC, 8'hff);
    send(8'h55, 8'h00, 8'h55);
    send(8'haa, 8'h55, 8'haa);
    send(8'haa, 8'haa, 8'haa);
  endtask

  task automatic t_full();
    @(posedge mclk);
    tx_ready <= 0;
    rx_valid <= 1;
    rx_data <= 8'h0f;
    repeat (8) begin
      @(posedge mclk);
      #1;
      check(rx_ready, 0, "taken while full");
      check(tx_valid, 0, "sample while full");
    end
    @(posedge mclk);
    tx_ready <= 1;
    wait_ack();
    check(tx_data, 8'haa, "late sample");
  endtask

  task automatic t_dirs();
    setup(MODE_SYNC, 8'hf0);
    @(posedge mclk);
    ext_val <= 8'h3c;
    repeat (6) @(posedge mclk);
    send(8'h96, 8'h0c, 8'h9c);
    check(pin_oe, 8'hf0, "dir held");
    setup(MODE_SYNC, 8'h00);
    send(8'hc3, 8'h3c, 8'h3c);
  endtask

  task automatic t_free();
    setup(MODE_FREE, 8'hff);
    held = pin_in;
    @(posedge mclk);
    rx_valid <= 1;
    rx_data <= 8'h5a;
    repeat (6) begin
      @(posedge mclk);
      #1;
      check(rx_ready, 0, "no tick take");
      check(pin_in, held, "hold");
    end
    @(posedge mclk);
    baud_tick <= 1;
    @(posedge mclk);
    baud_tick <= 0;
    #1;
    check(rx_ready, 1, "tick take");
    check(pin_sample_strobe_n, 0, "free rstb");
    check(tx_valid, 1, "free sample");
    @(posedge mclk);
    rx_valid <= 0;
    #1;
    check(pin_in, 8'h5a, "free pins");
    check(pin_update_strobe_n, 0, "free wstb");
    @(posedge mclk);
    baud_tick <= 1;
    @(posedge mclk);
    baud_tick <= 0;
    repeat (3) @(posedge mclk);
    #1;
    check(pin_in, 8'h5a, "tick no byte");
  endtask

  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    failures = 0;
    checked = 0;
    reset = 1;
    {setup_valid, baud_tick, rx_valid} = '0;
    {setup_mode, setup_dir_mask, rx_data, ext_val} = '0;
    tx_ready = 1;
    repeat (2) @(posedge mclk);
    reset <= 0;
    t_sync();
    t_full();
    t_dirs();
    t_free();
    print_verdict();
  end

  // About 75 cycles expected; generous margin
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
endmodule // test_usb_parallel_bit_bang_port
`default_nettype wire
